// ==== apc_pkg.sv ====
// Package: constants, codes and states of the slave parameter/configuration job handler
package apc_pkg;

  localparam int          SLV_W        = 6;
  localparam int          NUM_SLV      = 64;
  localparam int          STR_MAX      = 220;
  localparam logic [7:0]  STR_MAX_B    = 8'hdc;
  localparam logic [7:0]  REV_ZERO     = 8'h00;
  localparam logic [3:0]  NIB_ZERO     = 4'h0;
  localparam logic [3:0]  PARAM_MANAGED = 4'hf;
  localparam logic [3:0]  PARAM_DEFAULT = 4'hf;
  localparam logic [15:0] CFG_DEFAULT  = 16'hffff;
  // ---------------------------------------------------------------
  // Response record layout and offline phase length
  // ---------------------------------------------------------------
  localparam logic [7:0]  IDX_B2       = 8'h02;
  localparam logic [7:0]  IDX_STR0     = 8'h03;
  localparam logic [7:0]  LAST_SHORT   = 8'h03;
  localparam logic [7:0]  LAST_STR     = 8'hde;
  localparam logic [7:0]  OFFLINE_CYC  = 8'h10;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_STATUS   = 8'h04;
  localparam logic [7:0]  REG_JOBS     = 8'h08;
  localparam logic [7:0]  REG_PEEK     = 8'h0c;
  localparam logic [7:0]  REG_PPARAM   = 8'h10;
  localparam logic [2:0]  CTRL_RST     = 3'h0;
  localparam int          CTRL_PROT    = 0;
  localparam int          CTRL_PLUG    = 1;
  localparam int          CTRL_CTT_REJ = 2;

  typedef enum logic [2:0] {
    JOB_GET_PERM_PARAM = 3'h0, JOB_WRITE_PARAM = 3'h1, JOB_READ_PARAM = 3'h2,
    JOB_SET_PERM_CFG   = 3'h3, JOB_GET_PERM_CFG = 3'h4, JOB_READ_ACT_CFG = 3'h5,
    JOB_READ_PARAM_STR = 3'h6, JOB_UNUSED = 3'h7
  } apc_job_e;

  typedef enum logic [1:0] {
    OP_WR_PARAM = 2'h0, OP_RD_PARAM = 2'h1, OP_RD_CFG = 2'h2, OP_RD_STR = 2'h3
  } apc_op_e;

  typedef enum logic [3:0] {
    ST_OK = 4'h0, ST_HDR = 4'h1, ST_PARM = 4'h2, ST_REJECT = 4'h3, ST_PROT = 4'h4,
    ST_BUS = 4'h5, ST_STR_LONG = 4'h6, ST_NV = 4'h7, ST_CMD = 4'h8
  } apc_stat_e;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_CHECK = 3'h1, S_BUS_WAIT = 3'h2, S_STR_RX = 3'h3,
    S_NV_WAIT = 3'h4, S_OFFLINE = 3'h5, S_SEND = 3'h6
  } apc_state_e;

endpackage : apc_pkg

// ==== apc_job_handler.sv ====
// Module: job handler for slave parameter, configuration and parameter-string records
//
// Function
// R1: Record header bytes must both be zero
// R2: Parameter nibble low, upper nibble, byte3 zero
// R3: Get-permanent-parameter returns stored slave parameter
// R4: Combined-type slaves may reject get-permanent-parameter
// R5: Write-parameter forwards bits to slave on bus
// R6: Written parameter kept volatile, never in nonvolatile
// R7: Write response carries slave echo, may differ
// R8: Master-managed slaves: configured parameter reads F
// R9: Read-parameter returns slave current value, not echo
// R10: Set-configuration stores cfg and IDs nonvolatile/plug
// R11: Set-configuration refused in protected mode
// R12: Requester supplies F for unsupported ID1/ID2
// R13: Set-configuration passes offline then warm restart
// R14: Negative confirmation does not mean store failed
// R15: Get-configuration returns stored expected configuration
// R16: Read-actual-configuration returns detected bus configuration
// R17: Byte2 I/O cfg over ID, byte3 ID1 over ID2
// R18: Parameter string read from profile 7.4 slaves
// R19: String response max 220 bytes, count byte2
// R20: Over 220 bytes: abort, error, withhold data
// R21: Cyclic exchange with slave suspended during string
// R22: Count at byte2, string bytes at 3..222
//
// Design decisions made here: the strobed register port and the register offsets.
module apc_job_handler
  import apc_pkg::*;
(
  input  wire logic             clock_i,
  input  wire logic             reset_n_i,
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic [31:0]      reg_wdata_i,
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  output logic      [31:0]      reg_rdata_o,
  input  wire logic             job_valid_i,
  input  wire apc_job_e         job_code_i,
  input  wire logic [SLV_W-1:0] job_slave_i,
  input  wire logic             job_ctt_i,
  input  wire logic [7:0]       job_record_rev_upper_i,
  input  wire logic [7:0]       job_record_rev_lower_i,
  input  wire logic [7:0]       job_byte2_i,
  input  wire logic [7:0]       job_byte3_i,
  output logic                  job_busy_o,
  output logic                  job_done_o,
  output logic      [3:0]       job_status_o,
  output logic                  resp_valid_o,
  output logic      [7:0]       resp_byte_o,
  output logic                  resp_last_o,
  output logic                  bus_req_o,
  output logic      [1:0]       bus_op_o,
  output logic      [SLV_W-1:0] bus_slave_o,
  output logic      [3:0]       bus_wdata_o,
  output logic                  bus_abort_o,
  input  wire logic             bus_ack_i,
  input  wire logic             bus_err_i,
  input  wire logic [15:0]      bus_rdata_i,
  input  wire logic             str_valid_i,
  input  wire logic [7:0]       str_byte_i,
  output logic                  cyc_hold_o,
  output logic      [SLV_W-1:0] cyc_hold_slave_o,
  output logic                  nv_wr_o,
  output logic      [SLV_W-1:0] nv_slave_o,
  output logic      [15:0]      nv_data_o,
  output logic                  nv_plug_o,
  input  wire logic             nv_ack_i,
  input  wire logic             nv_ok_i,
  output logic                  offline_o
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [3:0]       perm_param   [NUM_SLV];
  logic [3:0]       vol_param    [NUM_SLV];
  logic [15:0]      expected_cfg_set [NUM_SLV];
  logic [7:0]       str_buf      [STR_MAX];
  logic [NUM_SLV-1:0] pp_vld_r, vp_vld_r, ec_vld_r;

  apc_state_e       st_r, st_nxt;
  apc_job_e         code_r;
  apc_stat_e        stat_r, stat_nxt;
  logic [SLV_W-1:0] slave_r, peek_r;
  logic             ctt_r, nv_ok_r, nv_ok_nxt;
  logic [7:0]       rev_u_r, rev_l_r, b2_r, b3_r, ob2_r, ob2_nxt, ob3_r, ob3_nxt;
  logic [7:0]       idx_r, idx_nxt, cnt_r, cnt_nxt, last_r, last_nxt, offl_r, offl_nxt;
  logic [2:0]       ctrl_r;
  logic [31:0]      jobs_r;
  logic             done_nxt, rv_nxt, rl_nxt, breq_nxt, abort_nxt, hold_nxt, nvw_nxt, offline_nxt;
  logic [7:0]       rbyte_nxt;
  apc_op_e          op_r, op_nxt;
  logic             vol_we, ec_we, buf_we;
  logic [15:0]      detected_cfg_set;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire hdr_bad   = (rev_u_r != REV_ZERO) || (rev_l_r != REV_ZERO);  // R1
  wire parm_bad  = (b2_r[7:4] != NIB_ZERO) || (b3_r != REV_ZERO);   // R2
  wire param_bit_0 = b2_r[0];
  wire param_bit_1 = b2_r[1];
  wire param_bit_2 = b2_r[2];
  wire param_bit_3 = b2_r[3];
  wire [3:0] wr_param = {param_bit_3, param_bit_2, param_bit_1, param_bit_0};
  wire [3:0] pp_rd   = pp_vld_r[slave_r] ? perm_param[slave_r] : PARAM_DEFAULT;
  wire [15:0] ec_rd  = ec_vld_r[slave_r] ? expected_cfg_set[slave_r] : CFG_DEFAULT;
  wire [7:0] buf_idx = idx_r - IDX_STR0;
  wire [7:0] buf_rd  = str_buf[buf_idx];
  wire       is_str  = (code_r == JOB_READ_PARAM_STR);
  wire       str_ovf = str_valid_i && (cnt_r == STR_MAX_B);
  wire [3:0] vp_rd   = vp_vld_r[peek_r] ? vol_param[peek_r] : PARAM_DEFAULT;
  wire [3:0] pk_pp   = pp_vld_r[peek_r] ? perm_param[peek_r] : PARAM_DEFAULT;
  wire [31:0] rd_sel =
    (reg_addr_i == REG_CTRL)   ? {29'h0, ctrl_r} :
    (reg_addr_i == REG_STATUS) ? {24'h0, stat_r, 1'b0, st_r} :
    (reg_addr_i == REG_JOBS)   ? jobs_r :
    (reg_addr_i == REG_PEEK)   ? {16'h0, vp_rd, pk_pp, 2'h0, peek_r} : 32'h0;
  wire ctrl_we = reg_wr_i && (reg_addr_i == REG_CTRL);
  wire peek_we = reg_wr_i && (reg_addr_i == REG_PEEK);
  wire pp_we   = reg_wr_i && (reg_addr_i == REG_PPARAM);

  // ---------------------------------------------------------------
  // Job sequencer
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    stat_nxt = stat_r;
    {ob2_nxt, ob3_nxt, idx_nxt, cnt_nxt, last_nxt, offl_nxt} = {ob2_r, ob3_r, idx_r, cnt_r, last_r, offl_r};
    nv_ok_nxt = nv_ok_r;
    op_nxt = op_r;
    {done_nxt, rv_nxt, rl_nxt, breq_nxt, abort_nxt, hold_nxt, nvw_nxt, offline_nxt} = '0;
    rbyte_nxt = REV_ZERO;
    {vol_we, ec_we, buf_we} = '0;
    case (st_r)
      S_IDLE: begin
        if (job_valid_i) begin
          st_nxt = S_CHECK;
        end
      end
      S_CHECK: begin
        idx_nxt = REV_ZERO;
        cnt_nxt = REV_ZERO;
        last_nxt = LAST_SHORT;
        ob3_nxt = REV_ZERO;
        st_nxt = S_SEND;
        if (hdr_bad) begin
          stat_nxt = ST_HDR;  // R1
          st_nxt = S_IDLE;
        end else begin
          case (code_r)
            JOB_GET_PERM_PARAM: begin
              if (ctt_r && ctrl_r[CTRL_CTT_REJ]) begin
                stat_nxt = ST_REJECT;  // R4
                st_nxt = S_IDLE;
              end else begin
                ob2_nxt = {NIB_ZERO, ctt_r ? PARAM_MANAGED : pp_rd};  // R3 R8
              end
            end
            JOB_WRITE_PARAM: begin
              if (parm_bad) begin
                stat_nxt = ST_PARM;  // R2
                st_nxt = S_IDLE;
              end else if (ctt_r) begin
                ob2_nxt = {NIB_ZERO, PARAM_MANAGED};  // R8
              end else begin
                vol_we = 1'b1;  // R6
                breq_nxt = 1'b1;  // R5
                op_nxt = OP_WR_PARAM;
                st_nxt = S_BUS_WAIT;
              end
            end
            JOB_READ_PARAM: begin
              breq_nxt = 1'b1;
              op_nxt = OP_RD_PARAM;
              st_nxt = S_BUS_WAIT;
            end
            JOB_SET_PERM_CFG: begin
              if (ctrl_r[CTRL_PROT]) begin
                stat_nxt = ST_PROT;  // R11
                st_nxt = S_IDLE;
              end else begin
                ec_we = 1'b1;  // R10
                nvw_nxt = 1'b1;  // R10
                ob2_nxt = b2_r;
                ob3_nxt = b3_r;
                st_nxt = S_NV_WAIT;
              end
            end
            JOB_GET_PERM_CFG: begin
              ob2_nxt = ec_rd[15:8];  // R15 R17
              ob3_nxt = ec_rd[7:0];
            end
            JOB_READ_ACT_CFG: begin
              breq_nxt = 1'b1;
              op_nxt = OP_RD_CFG;
              st_nxt = S_BUS_WAIT;
            end
            JOB_READ_PARAM_STR: begin
              breq_nxt = 1'b1;  // R18
              op_nxt = OP_RD_STR;
              hold_nxt = 1'b1;  // R21
              st_nxt = S_STR_RX;
            end
            default: begin
              stat_nxt = ST_CMD;
              st_nxt = S_IDLE;
            end
          endcase
        end
        done_nxt = (st_nxt == S_IDLE);
      end
      S_BUS_WAIT: begin
        if (bus_err_i) begin
          stat_nxt = ST_BUS;
          done_nxt = 1'b1;
          st_nxt = S_IDLE;
        end else if (bus_ack_i) begin
          if (code_r == JOB_READ_ACT_CFG) begin
            ob2_nxt = detected_cfg_set[15:8];  // R16 R17
            ob3_nxt = detected_cfg_set[7:0];
          end else begin
            ob2_nxt = {NIB_ZERO, bus_rdata_i[3:0]};  // R7 R9
          end
          st_nxt = S_SEND;
        end
      end
      S_STR_RX: begin
        hold_nxt = 1'b1;  // R21
        if (str_ovf) begin
          abort_nxt = 1'b1;  // R20
          stat_nxt = ST_STR_LONG;
          done_nxt = 1'b1;
          hold_nxt = 1'b0;
          st_nxt = S_IDLE;
        end else if (str_valid_i) begin
          buf_we = 1'b1;
          cnt_nxt = cnt_r + 8'h01;
        end else if (bus_err_i) begin
          stat_nxt = ST_BUS;
          done_nxt = 1'b1;
          hold_nxt = 1'b0;
          st_nxt = S_IDLE;
        end else if (bus_ack_i) begin
          ob2_nxt = cnt_r;  // R19
          last_nxt = LAST_STR;  // R22
          hold_nxt = 1'b0;
          st_nxt = S_SEND;
        end
      end
      S_NV_WAIT: begin
        if (nv_ack_i) begin
          nv_ok_nxt = nv_ok_i;
          offline_nxt = 1'b1;  // R13
          offl_nxt = OFFLINE_CYC;
          st_nxt = S_OFFLINE;
        end
      end
      S_OFFLINE: begin
        offline_nxt = 1'b1;
        offl_nxt = offl_r - 8'h01;
        if (offl_r == 8'h01) begin
          offline_nxt = 1'b0;  // R13
          if (nv_ok_r) begin
            st_nxt = S_SEND;
          end else begin
            stat_nxt = ST_NV;  // R14
            done_nxt = 1'b1;
            st_nxt = S_IDLE;
          end
        end
      end
      S_SEND: begin
        rv_nxt = 1'b1;
        if (idx_r < IDX_B2) begin
          rbyte_nxt = REV_ZERO;  // R1
        end else if (idx_r == IDX_B2) begin
          rbyte_nxt = ob2_r;
        end else begin
          rbyte_nxt = is_str ? buf_rd : ob3_r;  // R22
        end
        idx_nxt = idx_r + 8'h01;
        if (idx_r == last_r) begin
          rl_nxt = 1'b1;
          done_nxt = 1'b1;
          stat_nxt = ST_OK;
          st_nxt = S_IDLE;
        end
      end
      default: begin
        st_nxt = S_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // State and outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      st_r <= S_IDLE;
      stat_r <= ST_OK;
      code_r <= JOB_GET_PERM_PARAM;
      {slave_r, ctt_r, rev_u_r, rev_l_r, b2_r, b3_r} <= '0;
      {ob2_r, ob3_r, idx_r, cnt_r, last_r, offl_r, nv_ok_r} <= '0;
      op_r <= OP_WR_PARAM;
      {job_busy_o, job_done_o, job_status_o, resp_valid_o, resp_byte_o, resp_last_o} <= '0;
      {bus_req_o, bus_op_o, bus_slave_o, bus_wdata_o, bus_abort_o} <= '0;
      {cyc_hold_o, cyc_hold_slave_o, nv_wr_o, nv_slave_o, nv_data_o, nv_plug_o, offline_o} <= '0;
    end else begin
      if (st_r == S_IDLE && job_valid_i) begin
        {code_r, slave_r, ctt_r} <= {job_code_i, job_slave_i, job_ctt_i};
        {rev_u_r, rev_l_r, b2_r, b3_r} <= {job_record_rev_upper_i, job_record_rev_lower_i, job_byte2_i, job_byte3_i};
      end
      st_r <= st_nxt;
      stat_r <= stat_nxt;
      {ob2_r, ob3_r, idx_r, cnt_r, last_r, offl_r, nv_ok_r} <= {ob2_nxt, ob3_nxt, idx_nxt, cnt_nxt, last_nxt, offl_nxt, nv_ok_nxt};
      op_r <= op_nxt;
      job_busy_o <= (st_nxt != S_IDLE);
      job_done_o <= done_nxt;
      job_status_o <= stat_nxt;
      {resp_valid_o, resp_byte_o, resp_last_o} <= {rv_nxt, rbyte_nxt, rl_nxt};
      {bus_req_o, bus_op_o, bus_slave_o, bus_wdata_o, bus_abort_o} <= {breq_nxt, op_nxt, slave_r, wr_param, abort_nxt};
      {cyc_hold_o, cyc_hold_slave_o} <= {hold_nxt, slave_r};
      {nv_wr_o, nv_slave_o, nv_data_o} <= {nvw_nxt, slave_r, b2_r, b3_r};
      nv_plug_o <= ctrl_r[CTRL_PLUG];  // R10
      offline_o <= offline_nxt;
    end
  end

  // Arrays unreset; valid bits give defaults, except str_buf, which has none
  always_ff @(posedge clock_i) begin
    if (vol_we) vol_param[slave_r] <= wr_param;  // R6
    if (ec_we) expected_cfg_set[slave_r] <= {b2_r, b3_r};
    if (buf_we) str_buf[cnt_r] <= str_byte_i;
    if (pp_we) perm_param[reg_wdata_i[5:0]] <= reg_wdata_i[11:8];
  end

  // ---------------------------------------------------------------
  // Register slave
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      {pp_vld_r, vp_vld_r, ec_vld_r} <= '0;
      ctrl_r <= CTRL_RST;
      jobs_r <= 32'h0;
      peek_r <= '0;
      reg_rdata_o <= 32'h0;
    end else begin
      if (pp_we) pp_vld_r[reg_wdata_i[5:0]] <= 1'b1;
      if (vol_we) vp_vld_r[slave_r] <= 1'b1;
      if (ec_we) ec_vld_r[slave_r] <= 1'b1;
      if (ctrl_we) ctrl_r <= reg_wdata_i[2:0];
      if (peek_we) peek_r <= reg_wdata_i[5:0];
      if (done_nxt) jobs_r <= jobs_r + 32'h1;
      reg_rdata_o <= reg_rd_i ? rd_sel : 32'h0;
    end
  end

  // Detected configuration is the bus answer only
  assign detected_cfg_set = bus_rdata_i;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  sequence chk_ok;
    st_r == S_CHECK && !hdr_bad;
  endsequence

  AST_HDR_REJECT: assert property (st_r == S_CHECK && hdr_bad |=> job_done_o && job_status_o == ST_HDR && !resp_valid_o)  // R1
    else $error("bad header not refused");
  AST_PARM_NIBBLE: assert property (chk_ok and code_r == JOB_WRITE_PARAM && parm_bad |=> job_status_o == ST_PARM && !bus_req_o)  // R2
    else $error("bad parameter byte not refused");
  AST_PERM_READ: assert property (chk_ok and code_r == JOB_GET_PERM_PARAM && !ctt_r |-> ##4 resp_byte_o == {NIB_ZERO, $past(pp_rd, 4)})  // R3
    else $error("stored parameter not returned");
  AST_CTT_REJECT: assert property (chk_ok and code_r == JOB_GET_PERM_PARAM && ctt_r && ctrl_r[CTRL_CTT_REJ] |=> job_status_o == ST_REJECT)  // R4
    else $error("combined-type reject missing");
  AST_WR_FWD: assert property (chk_ok and code_r == JOB_WRITE_PARAM && !parm_bad && !ctt_r |=> bus_req_o && bus_op_o == OP_WR_PARAM && bus_wdata_o == $past(b2_r[3:0]))  // R5
    else $error("write parameter not forwarded");
  AST_NO_NV_WR: assert property (code_r != JOB_SET_PERM_CFG |-> !nv_wr_o)  // R6
    else $error("nonvolatile write outside set-configuration");
  AST_ECHO: assert property (st_r == S_BUS_WAIT && code_r == JOB_WRITE_PARAM && bus_ack_i && !bus_err_i |-> ##4 resp_byte_o == {NIB_ZERO, $past(bus_rdata_i[3:0], 4)})  // R7
    else $error("echo not returned");
  AST_MANAGED_F: assert property (chk_ok and code_r == JOB_WRITE_PARAM && !parm_bad && ctt_r |=> !bus_req_o ##3 resp_byte_o == {NIB_ZERO, PARAM_MANAGED})  // R8
    else $error("managed slave parameter not F");
  AST_PROT: assert property (chk_ok and code_r == JOB_SET_PERM_CFG && ctrl_r[CTRL_PROT] |=> job_status_o == ST_PROT && !nv_wr_o)  // R11
    else $error("set-configuration ran in protected mode");
  AST_OFFLINE_HOLD: assert property ($rose(offline_o) |-> offline_o[*8] ##[1:16] !offline_o)  // R13
    else $error("offline phase wrong length");
  AST_STR_ABORT: assert property (st_r == S_STR_RX && str_ovf |=> bus_abort_o && job_done_o && job_status_o == ST_STR_LONG && !resp_valid_o)  // R20
    else $error("overlong string not aborted");
  AST_HOLD: assert property (st_r == S_STR_RX |-> cyc_hold_o && cyc_hold_slave_o == slave_r)  // R21
    else $error("cyclic exchange not suspended");

endmodule : apc_job_handler

// ==== apc_core_model.sv ====
// Partner model: bus core and store beside the job handler
module apc_core_model
  import apc_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        bus_req_i,
  input  wire logic [1:0]  bus_op_i,
  input  wire logic [3:0]  bus_wdata_i,
  input  wire logic        nv_wr_i,
  input  wire logic [9:0]  lat_i,
  input  wire logic [15:0] val_i,
  input  wire logic [9:0]  str_n_i,
  input  wire logic        nv_ok_cfg_i,
  output logic             bus_ack_o = 1'b0,
  output logic [15:0]      bus_rdata_o = 16'h0000,
  output logic             str_valid_o = 1'b0,
  output logic [7:0]       str_byte_o = 8'h00,
  output logic             nv_ack_o = 1'b0,
  output logic             nv_ok_o = 1'b0,
  output logic [3:0]       last_wdata_o = 4'h0
);
  // ---------------------------------------------------------------
  // Bus core: latency, string, ack
  // ---------------------------------------------------------------
  initial begin
    forever begin
      @(posedge clock_i);
      if (bus_req_i === 1'b1) begin
        last_wdata_o <= bus_wdata_i;
        repeat (lat_i) @(posedge clock_i);
        if (bus_op_i == OP_RD_STR) begin
          // Overlong slave: one byte extra, no ack
          for (int i = 1; i <= str_n_i && i <= STR_MAX + 1; i++) begin
            str_valid_o <= 1'b1;
            str_byte_o  <= 8'(i);
            @(posedge clock_i);
          end
          str_valid_o <= 1'b0;
          str_byte_o  <= ~str_byte_o;
        end
        if (bus_op_i != OP_RD_STR || str_n_i <= STR_MAX) begin
          bus_ack_o   <= 1'b1;
          bus_rdata_o <= val_i;
          @(posedge clock_i);
          bus_ack_o   <= 1'b0;
          bus_rdata_o <= ~val_i;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Store: may nack though data kept
  // ---------------------------------------------------------------
  initial begin
    forever begin
      @(posedge clock_i);
      if (nv_wr_i === 1'b1) begin
        repeat (lat_i) @(posedge clock_i);
        nv_ack_o <= 1'b1;
        nv_ok_o  <= nv_ok_cfg_i;
        @(posedge clock_i);
        nv_ack_o <= 1'b0;
        nv_ok_o  <= ~nv_ok_cfg_i;
      end
    end
  end
endmodule : apc_core_model

// ==== tb_top.sv ====
// Testbench: jobs and register accesses into the job handler
module tb_top
  import apc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clock_i, reset_n_i, reg_wr_i, reg_rd_i, job_valid_i, job_ctt_i, bus_ack_i, bus_err_i;
  logic             str_valid_i, nv_ack_i, nv_ok_i, job_busy_o, job_done_o, resp_valid_o, resp_last_o;
  logic             bus_req_o, bus_abort_o, cyc_hold_o, nv_wr_o, nv_plug_o, offline_o, m_ok, abort_seen;
  logic [7:0]       reg_addr_i, job_record_rev_upper_i, job_record_rev_lower_i, job_byte2_i, job_byte3_i;
  logic [7:0]       resp_byte_o, str_byte_i;
  logic [31:0]      reg_wdata_i, reg_rdata_o;
  logic [15:0]      bus_rdata_i, nv_data_o, m_val;
  logic [16:0]      nv_cap;
  logic [SLV_W-1:0] job_slave_i, bus_slave_o, cyc_hold_slave_o, nv_slave_o;
  logic [SLV_W:0]   hold_cap;
  logic [3:0]       job_status_o, bus_wdata_o, m_wdata;
  logic [1:0]       bus_op_o;
  logic [9:0]       m_lat, m_n;
  apc_job_e         job_code_i;
  logic [7:0]       rq[$];
  int               bad_count, n_compared, off_cnt, jobs_done;

  apc_job_handler apc_job_handler_inst (
    .clock_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .job_valid_i,
    .job_code_i, .job_slave_i, .job_ctt_i, .job_record_rev_upper_i, .job_record_rev_lower_i, .job_byte2_i,
    .job_byte3_i, .job_busy_o, .job_done_o, .job_status_o, .resp_valid_o, .resp_byte_o, .resp_last_o,
    .bus_req_o, .bus_op_o, .bus_slave_o, .bus_wdata_o, .bus_abort_o, .bus_ack_i, .bus_err_i, .bus_rdata_i,
    .str_valid_i, .str_byte_i, .cyc_hold_o, .cyc_hold_slave_o, .nv_wr_o, .nv_slave_o, .nv_data_o,
    .nv_plug_o, .nv_ack_i, .nv_ok_i, .offline_o);

  apc_core_model apc_core_model_inst (
    .clock_i, .bus_req_i(bus_req_o), .bus_op_i(bus_op_o), .bus_wdata_i(bus_wdata_o),
    .nv_wr_i(nv_wr_o), .lat_i(m_lat), .val_i(m_val), .str_n_i(m_n), .nv_ok_cfg_i(m_ok),
    .bus_ack_o(bus_ack_i), .bus_rdata_o(bus_rdata_i), .str_valid_o(str_valid_i), .str_byte_o(str_byte_i),
    .nv_ack_o(nv_ack_i), .nv_ok_o(nv_ok_i), .last_wdata_o(m_wdata));

  // ---------------------------------------------------------------
  // Monitor on falling edge
  // ---------------------------------------------------------------
  always @(negedge clock_i) begin
    if (resp_valid_o === 1'b1) rq.push_back(resp_byte_o);
    if (offline_o === 1'b1) off_cnt++;
    if (nv_wr_o === 1'b1) nv_cap = {nv_plug_o, nv_data_o};
    if (str_valid_i === 1'b1) hold_cap = {cyc_hold_o, cyc_hold_slave_o};
    if (bus_abort_o === 1'b1) abort_seen = 1'b1;
  end

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h want %h", $time, g, e);
    end
  endtask : check

  task automatic check_rec(input logic [7:0] b2, input logic [7:0] b3);
    n_compared++;
    if (rq.size() != 4 || {rq[0], rq[1], rq[2], rq[3]} !== {16'h0000, b2, b3}) begin
      bad_count++;
      $display("MISMATCH t=%0t record %0d bytes, want %h %h", $time, rq.size(), b2, b3);
    end
  endtask : check_rec

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask : reg_write

  task automatic reg_check(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    @(negedge clock_i);
    check(reg_rdata_o, e);
  endtask : reg_check

  // Fields latched by handler on accept
  task automatic run_job(input apc_job_e c, input logic [5:0] s, input logic ct, input logic [15:0] hd,
                         input logic [7:0] b2, input logic [7:0] b3, input apc_stat_e st);
    int w;
    @(posedge clock_i);
    rq.delete();
    {job_code_i, job_slave_i, job_ctt_i, job_byte2_i, job_byte3_i} <= {c, s, ct, b2, b3};
    {job_record_rev_upper_i, job_record_rev_lower_i, job_valid_i} <= {hd, 1'b1};
    @(posedge clock_i);
    job_valid_i <= 1'b0;
    w = 0;
    while (job_done_o !== 1'b1 && w < 2000) begin
      @(posedge clock_i);
      w++;
    end
    @(posedge clock_i);
    jobs_done++;
    check(job_status_o, st);
    $display("job %s slave %0d status %h", c.name(), s, job_status_o);
  endtask : run_job

  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  // About 1100 cycles needed
  initial begin
    repeat (20000) @(posedge clock_i);
    bad_count++;
    report_and_stop();
  end

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    {reset_n_i, reg_wr_i, reg_rd_i, job_valid_i, job_ctt_i, bus_err_i, m_ok, abort_seen} = 8'h00;
    {reg_addr_i, reg_wdata_i, job_record_rev_upper_i, job_record_rev_lower_i} = 56'h0;
    {job_byte2_i, job_byte3_i, job_slave_i, m_val, m_lat, m_n} = 58'h0;
    job_code_i = JOB_GET_PERM_PARAM;
    repeat (2) @(posedge clock_i);
    reset_n_i <= 1'b1;
    reg_check(REG_CTRL, 32'h0);
    reg_check(8'hf0, 32'h0);
    run_job(JOB_READ_PARAM, 6'd1, 1'b0, 16'h0100, 8'h00, 8'h00, ST_HDR);
    run_job(JOB_READ_PARAM, 6'd1, 1'b0, 16'h0001, 8'h00, 8'h00, ST_HDR);
    run_job(JOB_WRITE_PARAM, 6'd1, 1'b0, 16'h0, 8'h19, 8'h00, ST_PARM);
    run_job(JOB_WRITE_PARAM, 6'd1, 1'b0, 16'h0, 8'h09, 8'h01, ST_PARM);
    reg_write(REG_PPARAM, 32'h0000_0305);
    m_val <= 16'h0006;
    run_job(JOB_WRITE_PARAM, 6'd5, 1'b0, 16'h0, 8'h09, 8'h00, ST_OK);
    check(m_wdata, 32'h9);
    check_rec(8'h06, 8'h00);
    run_job(JOB_GET_PERM_PARAM, 6'd5, 1'b0, 16'h0, 8'h00, 8'h00, ST_OK);
    check_rec(8'h03, 8'h00);
    m_val <= 16'h000c;
    m_lat <= 10'd5;
    run_job(JOB_READ_PARAM, 6'd5, 1'b0, 16'h0, 8'h00, 8'h00, ST_OK);
    check_rec(8'h0c, 8'h00);
    run_job(JOB_GET_PERM_PARAM, 6'd5, 1'b1, 16'h0, 8'h00, 8'h00, ST_OK);
    check_rec(8'h0f, 8'h00);
    reg_write(REG_CTRL, 32'h4);
    run_job(JOB_GET_PERM_PARAM, 6'd5, 1'b1, 16'h0, 8'h00, 8'h00, ST_REJECT);
    reg_write(REG_CTRL, 32'h1);
    run_job(JOB_SET_PERM_CFG, 6'd7, 1'b0, 16'h0, 8'h7a, 8'hff, ST_PROT);
    reg_write(REG_CTRL, 32'h2);
    m_ok <= 1'b1;
    off_cnt = 0;
    run_job(JOB_SET_PERM_CFG, 6'd7, 1'b0, 16'h0, 8'h7a, 8'hff, ST_OK);
    check(nv_cap, {1'b1, 16'h7aff});
    check(off_cnt, OFFLINE_CYC);
    reg_write(REG_CTRL, 32'h0);
    m_ok <= 1'b0;
    run_job(JOB_SET_PERM_CFG, 6'd8, 1'b0, 16'h0, 8'h31, 8'h2c, ST_NV);
    run_job(JOB_GET_PERM_CFG, 6'd8, 1'b0, 16'h0, 8'h00, 8'h00, ST_OK);
    check_rec(8'h31, 8'h2c);
    m_val <= 16'h5e3f;
    run_job(JOB_READ_ACT_CFG, 6'd9, 1'b0, 16'h0, 8'h00, 8'h00, ST_OK);
    check_rec(8'h5e, 8'h3f);
    m_n <= 10'd3;
    run_job(JOB_READ_PARAM_STR, 6'd10, 1'b0, 16'h0, 8'h00, 8'h00, ST_OK);
    check(rq.size(), 223);
    check({rq[0], rq[1], rq[2], rq[3], rq[5]}, 40'h0000_0301_03);
    check(hold_cap, {1'b1, 6'd10});
    m_n <= 10'd220;
    m_lat <= 10'd0;
    run_job(JOB_READ_PARAM_STR, 6'd11, 1'b0, 16'h0, 8'h00, 8'h00, ST_OK);
    check({rq[2], rq[222]}, 16'hdcdc);
    m_n <= 10'd221;
    run_job(JOB_READ_PARAM_STR, 6'd11, 1'b0, 16'h0, 8'h00, 8'h00, ST_STR_LONG);
    check({abort_seen, 8'(rq.size())}, 9'h100);
    reg_check(REG_JOBS, jobs_done);
    report_and_stop();
  end
endmodule : tb_top
